/* File: audio_serial_decode_trigger.sv */
// Audio serial stream decoder with per-channel compare trigger
// What this block does
// - Two-channel variants take left or right as first channel; left after reset.
// - Multiplexed mode decodes a set number of channels per frame, 8 after reset.
// - Data is sampled on rising or falling bit clock edge; rising after reset.
// - Data polarity active high or low; active high after reset.
// - Channel blocks start a set number of bits after frame start; 0 after reset.
// - Audio word length is 1 bit up to 32 bits; in multiplexed mode skip plus word must fit the channel length; 8 after reset.
// - Word select 0 is left, 1 right; inverted swaps them; normal after reset.
// - Multiplexed frame starts on rising sync edge, falling when inverted.
// - A readable count of decoded frames is kept.
// - Per channel compare: off, equal, not equal, greater, less, inside, outside.
// - Range compares use low value as start and high value as end.
// - Words and compare values are signed, bounded by the word length.
// - Every multiplexed channel has its own operator, low and high values.
// - Results combine by AND or OR within one frame, for data or window types.
// - Clock, data and word select each come from any analog or digital input.
// - Each line has its own threshold, 1.4 V after reset.
// - Variants are standard, left, right justified and multiplexed up to 8 channels.
// - Multiplexed frames split into channel blocks of set length, 8 after reset.
// - Multiplexed and left justified skip a set bit count, 1 after reset.
// - An error is flagged when two consecutive frames differ in length.
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module audio_serial_decode_trigger (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic [3:0]  ana_i,
  input  wire logic [15:0] dig_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic             trig_o,
  output logic      [15:0] clk_thr_o,
  output logic      [15:0] dat_thr_o,
  output logic      [15:0] ws_thr_o
);
  localparam int unsigned NC = audio_serial_pkg::N_CH;

  function automatic logic [31:0] sext(input logic [31:0] v, input logic [5:0] n);
    logic [5:0] sh;
    sh = 6'h20 - n;
    return 32'($signed(v << sh) >>> sh);
  endfunction

  function automatic logic hit(input logic [2:0] op, input logic [31:0] w, input logic [31:0] lo,
                               input logic [31:0] hi);
    logic ge;
    logic le;
    ge = $signed(w) >= $signed(lo);
    le = $signed(w) <= $signed(hi);
    case (audio_serial_pkg::cmp_op_e'(op))
      audio_serial_pkg::cmp_equal:         hit = (w == lo);
      audio_serial_pkg::cmp_not_equal:     hit = (w != lo);
      audio_serial_pkg::cmp_greater:       hit = $signed(w) > $signed(lo);
      audio_serial_pkg::cmp_less:          hit = $signed(w) < $signed(lo);
      audio_serial_pkg::cmp_inside_range:  hit = ge & le;
      audio_serial_pkg::cmp_outside_range: hit = ~(ge & le);
      default:                             hit = 1'b0;
    endcase
  endfunction

  function automatic logic pick(input logic [19:0] src, input logic [4:0] sel);
    return (sel < 5'(audio_serial_pkg::N_SRC)) ? src[sel] : 1'b0;
  endfunction

  function automatic logic [5:0] clamp_len(input logic [5:0] v);
    if (v == 6'h00) begin
      return 6'h01;
    end
    return (v > audio_serial_pkg::MAX_CHLEN) ? audio_serial_pkg::MAX_CHLEN : v;
  endfunction

  // Configuration
  logic [audio_serial_pkg::CTRL_W-1:0] ctrl_r;
  logic [3:0]  tdm_channel_count_r;
  logic [5:0]  ch_len_r;
  logic [5:0]  ch_off_r;
  logic [7:0]  frame_start_delay_r;
  logic [5:0]  audio_word_bits_r;
  logic [4:0]  clk_src_r;
  logic [4:0]  dat_src_r;
  logic [4:0]  ws_src_r;
  logic [2:0]  op_r [NC];
  logic [31:0] compare_low_value_r  [NC];
  logic [31:0] compare_high_value_r [NC];
  logic [31:0] word_r [NC];
  logic        err_r;
  logic [31:0] decoded_frame_count_r;

  // Decoder state
  audio_serial_pkg::dec_state_e st_r;
  logic        clk_prev_r;
  logic        ws_prev_r;
  logic [7:0]  dly_r;
  logic [6:0]  pos_r;
  logic [2:0]  ch_r;
  logic [31:0] sreg_r;
  logic [7:0]  got_r;
  logic [15:0] flen_r;
  logic [15:0] plen_r;
  logic [1:0]  nfs_r;
  logic        done_r;

  wire logic [1:0] variant_w   = ctrl_r[audio_serial_pkg::CTRL_VAR +: 2];
  wire logic       right_channel_first_w = ctrl_r[audio_serial_pkg::CTRL_RIGHT_CHANNEL_FIRST];
  wire logic       clk_fall_w  = ctrl_r[audio_serial_pkg::CTRL_FALL];
  wire logic       data_active_low_w = ctrl_r[audio_serial_pkg::CTRL_DATA_ACTIVE_LOW];
  wire logic       ws_inv_w    = ctrl_r[audio_serial_pkg::CTRL_WSINV];
  wire logic       func_or_w   = ctrl_r[audio_serial_pkg::CTRL_OR];
  wire logic [1:0] trig_type_w = ctrl_r[audio_serial_pkg::CTRL_TT +: 2];
  wire logic       tdm_w = (variant_w == audio_serial_pkg::var_tdm);
  wire logic       rj_w  = (variant_w == audio_serial_pkg::var_rj);

  // Line selection and synchronisers
  wire logic [19:0] src_w = {dig_i, ana_i};
  wire logic [2:0]  raw_w = {pick(src_w, clk_src_r), pick(src_w, ws_src_r), pick(src_w, dat_src_r)};
  logic [2:0] lv_w;
  audio_serial_pkg::line_s ln;
  assign ln = audio_serial_pkg::line_s'(lv_w);

  for (genvar g = 0; g < 3; g++) begin : g_sync
    line_sync u_sync (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .async_i (raw_w[g]),
      .level_o (lv_w[g])
    );
  end

  // Bit clock edge and frame detection
  wire logic smp_w = clk_fall_w ? (clk_prev_r & ~ln.clk) : (~clk_prev_r & ln.clk);
  wire logic bit_w = ln.dat ^ data_active_low_w;
  wire logic ws_chg_w = smp_w & (ln.ws != ws_prev_r);
  wire logic left_lvl_w = ws_inv_w;
  wire logic first_lvl_w = right_channel_first_w ? ~left_lvl_w : left_lvl_w;
  wire logic frame_w = tdm_w ? (ws_chg_w & (ln.ws == ~ws_inv_w))
                             : (ws_chg_w & (ln.ws == first_lvl_w));
  wire logic blk_w = tdm_w ? frame_w : ws_chg_w;
  wire logic [2:0] new_ch_w = (tdm_w || ln.ws == left_lvl_w) ? 3'h0 : 3'h1;
  wire logic [31:0] sreg_nxt_w = {sreg_r[30:0], bit_w};

  // Word capture position
  wire logic [5:0] skip_w = (variant_w == audio_serial_pkg::var_i2s) ? audio_serial_pkg::I2S_SKIP
                                                                     : ch_off_r;
  wire logic [6:0] cap_pos_w = 7'({1'b0, skip_w} + {1'b0, audio_word_bits_r} - 7'h01);
  wire logic cap_run_w = smp_w & ~blk_w & ~rj_w & (st_r == audio_serial_pkg::st_run) & (pos_r == cap_pos_w);
  // Right justified words end at the word select change, so the last bits shifted are the word
  wire logic cap_rj_w = smp_w & blk_w & rj_w & (st_r != audio_serial_pkg::st_idle);
  wire logic cap_w = cap_run_w | cap_rj_w;
  wire logic [7:0] cap_oh_w = cap_w ? (8'h01 << ch_r) : 8'h00;
  wire logic [2:0] last_ch_w = tdm_w ? 3'(tdm_channel_count_r - 4'h1)
                                     : (right_channel_first_w ? 3'h0 : 3'h1);
  wire logic [7:0] need_w = tdm_w ? (8'hFF >> (4'h8 - tdm_channel_count_r)) : 8'h03;
  wire logic done_w = cap_w & (ch_r == last_ch_w) & (((got_r | cap_oh_w) & need_w) == need_w);
  wire logic err_set_w = smp_w & frame_w & (nfs_r == 2'h2) & (flen_r != plen_r);

  // Decoder sequence
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_r       <= audio_serial_pkg::st_idle;
      clk_prev_r <= 1'b0;
      ws_prev_r  <= 1'b0;
      dly_r      <= 8'h00;
      pos_r      <= 7'h00;
      ch_r       <= 3'h0;
      sreg_r     <= 32'h0000_0000;
      got_r      <= 8'h00;
    end else begin
      clk_prev_r <= ln.clk;
      if (smp_w) begin
        ws_prev_r <= ln.ws;
        sreg_r    <= sreg_nxt_w;
        got_r     <= frame_w ? 8'h00 : (got_r | cap_oh_w);
        if (blk_w) begin
          ch_r  <= new_ch_w;
          pos_r <= 7'h01;
          dly_r <= frame_start_delay_r - 8'h01;
          st_r  <= (frame_start_delay_r == 8'h00) ? audio_serial_pkg::st_run : audio_serial_pkg::st_delay;
        end else begin
          case (st_r)
            audio_serial_pkg::st_delay: begin
              if (dly_r == 8'h00) begin
                st_r  <= audio_serial_pkg::st_run;
                pos_r <= 7'h01;
              end else begin
                dly_r <= dly_r - 8'h01;
              end
            end
            audio_serial_pkg::st_run: begin
              if (tdm_w && pos_r == 7'(ch_len_r - 6'h01)) begin
                pos_r <= 7'h00;
                ch_r  <= ch_r + 3'h1;
                if (ch_r == last_ch_w) begin
                  st_r <= audio_serial_pkg::st_idle;
                end
              end else if (pos_r != 7'h7F) begin
                pos_r <= pos_r + 7'h01;
              end
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // Frame length check
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      flen_r <= 16'h0000;
      plen_r <= 16'h0000;
      nfs_r  <= 2'h0;
      err_r  <= 1'b0;
    end else begin
      if (smp_w) begin
        flen_r <= frame_w ? 16'h0001 : ((flen_r == 16'hFFFF) ? flen_r : flen_r + 16'h0001);
      end
      if (smp_w && frame_w) begin
        plen_r <= flen_r;
        nfs_r  <= (nfs_r == 2'h2) ? nfs_r : nfs_r + 2'h1;
      end
      // A new error wins over a clear in the same cycle
      err_r <= err_set_w | (err_r & ~(wr_i && addr_i == audio_serial_pkg::A_STAT && wdata_i[0]));
    end
  end

  // Per-channel settings, words and compare results
  logic [NC-1:0] on_w;
  logic [NC-1:0] hit_w;
  for (genvar i = 0; i < NC; i++) begin : g_ch
    wire logic wsel_w = wr_i && addr_i[4:2] == 3'(i) && addr_i[1:0] == 2'h0;
    always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
        op_r[i]                 <= 3'h0;
        compare_low_value_r[i]  <= 32'h0000_0000;
        compare_high_value_r[i] <= 32'h0000_0000;
        word_r[i]               <= 32'h0000_0000;
      end else begin
        if (wsel_w && addr_i[7:5] == audio_serial_pkg::BANK_OP) begin
          op_r[i] <= wdata_i[2:0];
        end
        if (wsel_w && addr_i[7:5] == audio_serial_pkg::BANK_LO) begin
          compare_low_value_r[i] <= wdata_i;
        end
        if (wsel_w && addr_i[7:5] == audio_serial_pkg::BANK_HI) begin
          compare_high_value_r[i] <= wdata_i;
        end
        if (cap_w && ch_r == 3'(i)) begin
          word_r[i] <= sext(sreg_nxt_w, audio_word_bits_r);
        end
      end
    end
    // Limits are cut to the word length so they compare in the word's own range
    assign hit_w[i] = hit(op_r[i], word_r[i], sext(compare_low_value_r[i], audio_word_bits_r),
                          sext(compare_high_value_r[i], audio_word_bits_r));
    assign on_w[i] = (op_r[i] != 3'h0) && (need_w[i] || !tdm_w && i < 2);
  end

  // Channels set to off take no part; with all off nothing can fire
  wire logic all_w  = &(hit_w | ~on_w);
  wire logic any_w  = |(hit_w & on_w);
  wire logic cond_w = (|on_w) & (func_or_w ? any_w : all_w);
  wire logic type_ok_w = (trig_type_w == audio_serial_pkg::trig_data) ||
                         (trig_type_w == audio_serial_pkg::trig_window);

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      done_r                <= 1'b0;
      trig_o                <= 1'b0;
      decoded_frame_count_r <= 32'h0000_0000;
    end else begin
      done_r <= done_w;
      trig_o <= done_r & cond_w & type_ok_w;
      if (done_w) begin
        decoded_frame_count_r <= decoded_frame_count_r + 32'h0000_0001;
      end
    end
  end

  // Global configuration registers
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ctrl_r              <= audio_serial_pkg::RST_CTRL;
      tdm_channel_count_r <= audio_serial_pkg::RST_TDMCNT;
      ch_len_r            <= audio_serial_pkg::RST_CHLEN;
      ch_off_r            <= audio_serial_pkg::RST_CHOFF;
      frame_start_delay_r <= audio_serial_pkg::RST_FDLY;
      audio_word_bits_r   <= audio_serial_pkg::RST_WBITS;
      clk_src_r           <= audio_serial_pkg::RST_SRC_CLK;
      dat_src_r           <= audio_serial_pkg::RST_SRC_DAT;
      ws_src_r            <= audio_serial_pkg::RST_SRC_WS;
      clk_thr_o           <= audio_serial_pkg::RST_THR_MV;
      dat_thr_o           <= audio_serial_pkg::RST_THR_MV;
      ws_thr_o            <= audio_serial_pkg::RST_THR_MV;
    end else if (wr_i) begin
      case (addr_i)
        audio_serial_pkg::A_CTRL:    ctrl_r <= wdata_i[audio_serial_pkg::CTRL_W-1:0];
        audio_serial_pkg::A_TDMCNT:  tdm_channel_count_r <= (wdata_i[3:0] == 4'h0) ? 4'h1 :
                                                            (wdata_i[3:0] > 4'h8) ? 4'h8 : wdata_i[3:0];
        audio_serial_pkg::A_CHLEN:   ch_len_r <= clamp_len(wdata_i[5:0]);
        audio_serial_pkg::A_CHOFF:   ch_off_r <= wdata_i[5:0];
        audio_serial_pkg::A_FDLY:    frame_start_delay_r <= wdata_i[7:0];
        audio_serial_pkg::A_WBITS:   audio_word_bits_r <= clamp_len(wdata_i[5:0]);
        audio_serial_pkg::A_SRC: begin
          clk_src_r <= wdata_i[audio_serial_pkg::SRC_CLK +: 5];
          dat_src_r <= wdata_i[audio_serial_pkg::SRC_DAT +: 5];
          ws_src_r  <= wdata_i[audio_serial_pkg::SRC_WS +: 5];
        end
        audio_serial_pkg::A_THR_CLK: clk_thr_o <= wdata_i[15:0];
        audio_serial_pkg::A_THR_DAT: dat_thr_o <= wdata_i[15:0];
        audio_serial_pkg::A_THR_WS:  ws_thr_o <= wdata_i[15:0];
        default: begin
        end
      endcase
    end
  end

  // Read selection
  wire logic [2:0] rbank_w = addr_i[7:5];
  wire logic [2:0] ridx_w  = addr_i[4:2];
  wire logic       raln_w  = (addr_i[1:0] == 2'h0);
  wire logic [31:0] rd_ch_w =
    !raln_w                                 ? 32'h0000_0000 :
    (rbank_w == audio_serial_pkg::BANK_OP)  ? {29'h0000_0000, op_r[ridx_w]} :
    (rbank_w == audio_serial_pkg::BANK_LO)  ? compare_low_value_r[ridx_w] :
    (rbank_w == audio_serial_pkg::BANK_HI)  ? compare_high_value_r[ridx_w] : 32'h0000_0000;
  wire logic [31:0] rd_mux_w =
    (addr_i == audio_serial_pkg::A_CTRL)    ? {23'h00_0000, ctrl_r} :
    (addr_i == audio_serial_pkg::A_TDMCNT)  ? {28'h000_0000, tdm_channel_count_r} :
    (addr_i == audio_serial_pkg::A_CHLEN)   ? {26'h000_0000, ch_len_r} :
    (addr_i == audio_serial_pkg::A_CHOFF)   ? {26'h000_0000, ch_off_r} :
    (addr_i == audio_serial_pkg::A_FDLY)    ? {24'h00_0000, frame_start_delay_r} :
    (addr_i == audio_serial_pkg::A_WBITS)   ? {26'h000_0000, audio_word_bits_r} :
    (addr_i == audio_serial_pkg::A_SRC)     ? {11'h000, ws_src_r, 3'h0, dat_src_r, 3'h0, clk_src_r} :
    (addr_i == audio_serial_pkg::A_THR_CLK) ? {16'h0000, clk_thr_o} :
    (addr_i == audio_serial_pkg::A_THR_DAT) ? {16'h0000, dat_thr_o} :
    (addr_i == audio_serial_pkg::A_THR_WS)  ? {16'h0000, ws_thr_o} :
    (addr_i == audio_serial_pkg::A_STAT)    ? {31'h0000_0000, err_r} :
    (addr_i == audio_serial_pkg::A_FCNT)    ? decoded_frame_count_r : rd_ch_w;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= rd_i ? rd_mux_w : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

/* File: audio_serial_pkg.sv */
// Shared constants, types and register map of the audio serial decode trigger
package audio_serial_pkg;
  localparam int unsigned N_CH  = 8;
  localparam int unsigned N_SRC = 20;

  // Register byte addresses
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_TDMCNT  = 8'h04;
  localparam logic [7:0] A_CHLEN   = 8'h08;
  localparam logic [7:0] A_CHOFF   = 8'h0C;
  localparam logic [7:0] A_FDLY    = 8'h10;
  localparam logic [7:0] A_WBITS   = 8'h14;
  localparam logic [7:0] A_SRC     = 8'h18;
  localparam logic [7:0] A_THR_CLK = 8'h1C;
  localparam logic [7:0] A_THR_DAT = 8'h20;
  localparam logic [7:0] A_THR_WS  = 8'h24;
  localparam logic [7:0] A_STAT    = 8'h28;
  localparam logic [7:0] A_FCNT    = 8'h2C;
  // Per-channel banks: address bits 7:5 pick the bank, 4:2 the channel
  localparam logic [2:0] BANK_OP   = 3'h2;
  localparam logic [2:0] BANK_LO   = 3'h3;
  localparam logic [2:0] BANK_HI   = 3'h4;

  // Control register fields
  localparam int unsigned CTRL_VAR    = 0;
  localparam int unsigned CTRL_RIGHT_CHANNEL_FIRST = 2;
  localparam int unsigned CTRL_FALL   = 3;
  localparam int unsigned CTRL_DATA_ACTIVE_LOW = 4;
  localparam int unsigned CTRL_WSINV  = 5;
  localparam int unsigned CTRL_OR     = 6;
  localparam int unsigned CTRL_TT     = 7;
  localparam int unsigned CTRL_W      = 9;
  localparam int unsigned SRC_CLK     = 0;
  localparam int unsigned SRC_DAT     = 8;
  localparam int unsigned SRC_WS      = 16;

  // Reset values
  localparam logic [CTRL_W-1:0] RST_CTRL = 9'h000;
  localparam logic [3:0]  RST_TDMCNT = 4'h8;
  localparam logic [5:0]  RST_CHLEN  = 6'h08;
  localparam logic [5:0]  RST_CHOFF  = 6'h01;
  localparam logic [7:0]  RST_FDLY   = 8'h00;
  localparam logic [5:0]  RST_WBITS  = 6'h08;
  localparam logic [4:0]  RST_SRC_CLK = 5'h01;
  localparam logic [4:0]  RST_SRC_DAT = 5'h02;
  localparam logic [4:0]  RST_SRC_WS  = 5'h00;
  localparam logic [15:0] RST_THR_MV = 16'h0578;
  localparam logic [5:0]  MAX_CHLEN  = 6'h20;
  localparam logic [5:0]  I2S_SKIP   = 6'h01;

  typedef enum logic [1:0] {var_i2s, var_lj, var_rj, var_tdm} protocol_variant_e;
  typedef enum logic [2:0] {cmp_off, cmp_equal, cmp_not_equal, cmp_greater, cmp_less,
                            cmp_inside_range, cmp_outside_range} cmp_op_e;
  typedef enum logic [1:0] {trig_data, trig_window, trig_wsel, trig_error} trig_type_e;
  typedef enum logic [1:0] {st_idle, st_delay, st_run} dec_state_e;

  typedef struct packed {
    logic clk;
    logic ws;
    logic dat;
  } line_s;
endpackage

/* File: line_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module line_sync (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic async_i,
  output logic      level_o
);
  logic [2:0] s_r;

  // Stage 0 feeds only stage 1; a change counts once stages 1 and 2 agree
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s_r     <= 3'h0;
      level_o <= 1'b0;
    end else begin
      s_r <= {s_r[1:0], async_i};
      if (s_r[1] == s_r[2]) begin
        level_o <= s_r[2];
      end
    end
  end
endmodule
`default_nettype wire

/* File: audio_serial_decode_trigger_asserts.sv */
// Port-level assertions for the audio serial decode trigger
`timescale 1ns/1ps
`default_nettype none
module audio_serial_decode_trigger_asserts (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic [3:0]  ana_i,
  input wire logic [15:0] dig_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        trig_o,
  input wire logic [15:0] clk_thr_o,
  input wire logic [15:0] dat_thr_o,
  input wire logic [15:0] ws_thr_o
);
  logic [1:0]  tt_r;
  wire  [15:0] wlo    = wdata_i[15:0];
  wire         wr_clk = wr_i && addr_i == audio_serial_pkg::A_THR_CLK;
  wire         wr_dat = wr_i && addr_i == audio_serial_pkg::A_THR_DAT;
  wire         wr_ws  = wr_i && addr_i == audio_serial_pkg::A_THR_WS;
  wire         rd_ws  = rd_i && addr_i == audio_serial_pkg::A_THR_WS;
  // Last written trigger type; a few cycles of history cover a frame finishing mid-write
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      tt_r <= 2'h0;
    end else if (wr_i && addr_i == audio_serial_pkg::A_CTRL) begin
      tt_r <= wdata_i[8:7];
    end
  end
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  a_trig_pulse_apart: assert property (trig_o |=> !trig_o [*8])
    else $error("trigger pulse too long or too close");
  a_trig_type_quiet: assert property (tt_r[1] && $past(tt_r[1], 3) |-> !trig_o)
    else $error("trigger in a non-data type");
  a_clk_thr_hold: assert property (!wr_clk |=> $stable(clk_thr_o))
    else $error("clock threshold moved without a write");
  a_clk_thr_write: assert property (wr_clk |=> clk_thr_o == $past(wlo))
    else $error("clock threshold not written");
  a_dat_thr_write: assert property (wr_dat |=> dat_thr_o == $past(wlo))
    else $error("data threshold not written");
  a_ws_thr_write: assert property (wr_ws |=> ws_thr_o == $past(wlo))
    else $error("select threshold not written");
  a_ws_thr_read: assert property (rd_ws |=> rdata_o == {16'h0000, $past(ws_thr_o)})
    else $error("select threshold read back wrong");
  a_rdata_idle_zero: assert property (!rd_i |=> rdata_o == 32'h0000_0000)
    else $error("read data outside a read cycle");
endmodule
bind audio_serial_decode_trigger audio_serial_decode_trigger_asserts u_asserts (
  .clk_i(clk_i), .rstn_i(rstn_i), .ana_i(ana_i), .dig_i(dig_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .trig_o(trig_o), .clk_thr_o(clk_thr_o),
  .dat_thr_o(dat_thr_o), .ws_thr_o(ws_thr_o));
`default_nettype wire

/* File: audio_tx_model.sv */
// Audio transmitter model driving bit clock, word select and data
`timescale 1ns/1ps
`default_nettype none
module audio_tx_model (
  input  wire logic fall_i,
  output logic      bclk_o,
  output logic      ws_o,
  output logic      dat_o
);
  initial begin
    bclk_o = 1'b0;
    ws_o = 1'b0;
    dat_o = 1'b0;
  end
  // Lines change mid-way through the idle phase, well clear of the sampling edge
  task automatic play(input logic [255:0] wv, input logic [255:0] dv, input int n);
    for (int i = 0; i < n; i++) begin
      bclk_o = fall_i;
      #31.25;
      ws_o = wv[i];
      dat_o = dv[i];
      #31.25;
      bclk_o = ~fall_i;
      #62.5;
    end
    // Released line: the clock stands still and data no longer shows the last bit
    dat_o = ~dat_o;
  endtask
endmodule
`default_nettype wire

/* File: audio_serial_decode_trigger_tb.sv */
// Self-checking bench for the audio serial decode trigger
`timescale 1ns/1ps
`default_nettype none
module audio_serial_decode_trigger_tb;
  localparam logic [31:0] RST_V [12] = '{32'h0, 32'h8, 32'h8, 32'h1, 32'h0, 32'h8, 32'h0000_0201,
                                         32'h0578, 32'h0578, 32'h0578, 32'h0, 32'h0};
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        fall = 1'b0;
  logic [31:0] noise_r = 32'h0000_5A5A;
  logic [31:0] seed = 32'h0000_1A97;
  logic [31:0] mismatches = 0, checks = 0, trig_cnt = 0, cyc = 0;
  logic [31:0] rdata_o;
  logic        trig_o;
  wire         bclk, ws, dat;
  logic [7:0]  wd [8];
  logic [2:0]  op [8];
  logic [31:0] lo [8], hi [8];

  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] rnd();
    seed = step(seed);
    return seed;
  endfunction
  function automatic logic hit(input logic [2:0] o, input logic signed [7:0] w, l, h);
    case (o)
      3'h1: return w == l;
      3'h2: return w != l;
      3'h3: return w > l;
      3'h4: return w < l;
      3'h5: return w >= l && w <= h;
      3'h6: return w < l || w > h;
      default: return 1'b0;
    endcase
  endfunction

  audio_serial_decode_trigger DUT (
    .clk_i(clk_i), .rstn_i(rstn_i), .ana_i({noise_r[0], dat, bclk, ws}), .dig_i(noise_r[31:16]),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .trig_o(trig_o),
    .clk_thr_o(), .dat_thr_o(), .ws_thr_o());
  audio_tx_model tx (.fall_i(fall), .bclk_o(bclk), .ws_o(ws), .dat_o(dat));

  always #2.5 clk_i = ~clk_i;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Noise on unused inputs; also the hang guard and trigger pulse counter
  always @(posedge clk_i) begin
    noise_r <= step(noise_r);
    cyc <= cyc + 1;
    if (trig_o === 1'b1) trig_cnt <= trig_cnt + 1;
    if (cyc == 32'd60000) begin
      mismatches = mismatches + 1;
      final_report();
    end
  end

  initial begin
    logic [255:0] wv, dv;
    logic [31:0]  v, ctl, frames, base;
    int           n, q, j, r, c, p, k, nch, dly, skp;
    logic         tdm, f, any, all, act;
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (k = 0; k < 12; k++) begin
      rd(8'(4 * k), v);
      chk(v, RST_V[k]);
    end
    rd(8'hFC, v);
    chk(v, 32'h0);
    for (k = 0; k < 3; k++) begin
      base = rnd() & 32'h0000_FFFF;
      wr(audio_serial_pkg::A_THR_CLK + 8'(4 * k), base);
      rd(audio_serial_pkg::A_THR_CLK + 8'(4 * k), v);
      chk(v, base);
    end
    wr(audio_serial_pkg::A_CHLEN, 32'h10);
    frames = 0;
    for (k = 0; k < 16; k++) begin
      tdm = k >= 8;
      ctl = rnd() & 32'h0000_01FC;
      ctl[1:0] = tdm ? 2'h3 : {1'b0, k[0]};
      nch = tdm ? k % 8 + 1 : 2;
      dly = rnd() % 4;
      skp = rnd() % 4;
      for (c = 0; c < 8; c++) begin
        wd[c] = rnd();
        op[c] = k == 0 ? 3'h0 : 3'(rnd() % 7);
        lo[c] = rnd();
        hi[c] = rnd();
      end
      // Most negative word against most positive limit, forced to fire
      if (k == 1) begin
        wd[0] = 8'h80;
        op[0] = 3'h4;
        lo[0] = 32'h7F;
        ctl[8:6] = 3'b001;
      end
      wr(audio_serial_pkg::A_CTRL, ctl);
      wr(audio_serial_pkg::A_TDMCNT, nch);
      wr(audio_serial_pkg::A_CHOFF, skp);
      wr(audio_serial_pkg::A_FDLY, dly);
      for (c = 0; c < 8; c++) begin
        wr({audio_serial_pkg::BANK_OP, 3'(c), 2'b00}, op[c]);
        wr({audio_serial_pkg::BANK_LO, 3'(c), 2'b00}, lo[c]);
        wr({audio_serial_pkg::BANK_HI, 3'(c), 2'b00}, hi[c]);
      end
      if (ctl[1:0] == 2'h0) skp = 1;
      fall = ctl[3];
      f = ctl[2] ^ ctl[5];
      n = tdm ? 2 + dly + nch * 16 : 34;
      for (p = 0; p < n; p++) begin
        q = p - 2;
        wv[p] = tdm ? (q == 0) ^ ctl[5] : (q < 0 || q >= 16) ? !f : f;
        j = tdm ? (q - dly) / 16 : q / 16;
        r = tdm ? (q - dly) % 16 - skp : q % 16 - dly - skp;
        c = tdm ? j : j ^ ctl[2];
        dv[p] = (q >= 0 && r >= 0 && r < 8) ? wd[c][7 - r] ^ ctl[4] : (p > 0 ? !dv[p - 1] : 1'b0);
      end
      base = trig_cnt;
      tx.play(wv, dv, n);
      repeat (20) @(posedge clk_i);
      any = 1'b0;
      all = 1'b1;
      act = 1'b0;
      for (c = 0; c < nch; c++) begin
        if (op[c] != 3'h0) begin
          act = 1'b1;
          any |= hit(op[c], wd[c], lo[c][7:0], hi[c][7:0]);
          all &= hit(op[c], wd[c], lo[c][7:0], hi[c][7:0]);
        end
      end
      chk(trig_cnt - base, {31'h0, !ctl[8] && act && (ctl[6] ? any : all)});
      frames = frames + 1;
      rd(audio_serial_pkg::A_FCNT, v);
      chk(v, frames);
      if (k == 7 || k == 15) begin
        rd(audio_serial_pkg::A_STAT, v);
        chk(v, {31'h0, k == 15});
      end
    end
    wr(audio_serial_pkg::A_STAT, 32'h1);
    rd(audio_serial_pkg::A_STAT, v);
    chk(v, 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
